// ==== logic/mcs_top.sv ====
// Purpose: Input routing, bias source control and saturation status registers.
// Assumes: Classic Wishbone slave, 32-bit data, byte address = 4 x index.
// Notes:   Register data sits in the low byte; upper bits read as zero.
`include "mcs_map.svh"

// Contract
// R1: Bits 7:6 of the input select register route the path: 00 voltage, 01 ext A, 10 ext B, 11 internal sensor, reset voltage.
// R2: Bit 4 of the input select register connects the current source to the selected input, reset off.
// R3: Bit 3 of the input select register connects the internal source to the high shunt sense pin.
// R4: Bit 2 of the input select register connects a source to the low shunt sense pin.
// R5: Software keeps bit 5 of the input select register at zero.
// R6: Bits 7:3 of the bias setting register hold the five-bit source level code, reset zero, bits 2:0 reserved.
// R7: Bit 7 of the saturation register shows current channel saturation, read only, reset zero.
// R8: Bit 6 of the saturation register shows voltage channel saturation, bits 5:0 reserved.
// R9: Writes to the saturation register change nothing.
module mcs_top
    import mcs_pkg::*;
(
    // Clock and reset.
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    // Wishbone slave.
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [`MCS_ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic [31:0]               wb_dat_o,
    output logic                      wb_ack_o,
    // Saturation levels from the data paths.
    input  wire logic                 cur_sat_i,
    input  wire logic                 volt_sat_i,
    // Measurement input selection.
    output logic [1:0]                input_sel_o,
    output logic                      route_voltage_o,
    output logic                      route_ext_temp_input_a_o,
    output logic                      route_ext_temp_input_b_o,
    output logic                      route_int_temp_o,
    // Current source switches.
    output logic                      src_to_input_o,
    output logic                      src_on_voltage_o,
    output logic                      src_on_ext_temp_input_a_o,
    output logic                      src_on_ext_temp_input_b_o,
    output logic                      src_on_int_temp_o,
    output logic                      src_to_shunt_sense_high_o,
    output logic                      src_to_shunt_sense_low_o,
    // Current source level.
    output logic [4:0]                bias_code_o,
    // Interrupt.
    output logic                      irq_o
);

    // ============================================================
    // Helpers

    // True when the byte address hits the given register index.
    function automatic logic hit(
        input logic [`MCS_ADR_W-1:0] adr,
        input logic [`MCS_IDX_W-1:0] idx
    );
        hit = (adr[`MCS_IDX_HI:`MCS_IDX_LO] == idx);
    endfunction

    // One-hot decode of an input choice, bit n for code n.
    function automatic logic [3:0] onehot(input mcs_input_t sel);
        logic [3:0] v;
        v = 4'h0;
        case (sel)
            MCS_IN_VOLT:     v = 4'h1;
            MCS_IN_EXT_A:    v = 4'h2;
            MCS_IN_EXT_B:    v = 4'h4;
            MCS_IN_INT_TEMP: v = 4'h8;
            default:         v = 4'h0;
        endcase
        onehot = v;
    endfunction

    // ============================================================
    // State

    mcs_state_t st;
    mcs_state_t next_st;

    logic [1:0] evt_status;
    logic [1:0] sat_live;

    // Current saturation in bit 1, voltage in bit 0.
    assign sat_live = {cur_sat_i, volt_sat_i};

    // ============================================================
    // Sticky saturation events

    // Onsets of saturation become interrupt status bits.
    mcs_sat_events u_events (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .sat_i    (sat_live),
        .clr_i    (st.clr),
        .status_o (evt_status)
    );

    // ============================================================
    // Next state

    // Bus decode, register writes, read mux and output decode.
    always_comb begin
        logic       req;
        logic       wr;
        logic [7:0] wbyte;
        logic [7:0] rbyte;
        logic [7:0] stat_byte;
        logic [7:0] mask_byte;
        logic [7:0] sat_byte;
        logic [7:0] ais_byte;
        logic [7:0] bias_byte;
        req       = wb_cyc_i && wb_stb_i;
        wr        = 1'b0;
        wbyte     = wb_dat_i[7:0];
        rbyte     = `MCS_RST_BYTE;
        stat_byte = `MCS_RST_BYTE;
        mask_byte = `MCS_RST_BYTE;
        sat_byte  = `MCS_RST_BYTE;
        ais_byte  = `MCS_RST_BYTE;
        bias_byte = `MCS_RST_BYTE;
        next_st   = st;
        next_st.clr = 2'h0;

        // Readback images; reserved bits read as zero.
        ais_byte[`MCS_AIS_SEL_HI:`MCS_AIS_SEL_LO] = st.sel;
        ais_byte[`MCS_AIS_SRC_SEL]  = st.src_sel;
        ais_byte[`MCS_AIS_SRC_HIGH] = st.src_high;
        ais_byte[`MCS_AIS_SRC_LOW]  = st.src_low;
        bias_byte[`MCS_BIAS_HI:`MCS_BIAS_LO] = st.code;
        sat_byte[`MCS_SAT_HI:`MCS_SAT_LO]   = st.sat; // see R7 see R8
        stat_byte[`MCS_SAT_HI:`MCS_SAT_LO]  = evt_status;
        mask_byte[`MCS_SAT_HI:`MCS_SAT_LO]  = st.mask;

        // Each request gets one ack cycle; ack drops the cycle after.
        case (st.bus)
            MCS_BUS_IDLE: begin
                if (req) begin
                    next_st.bus = MCS_BUS_ACK;
                    wr          = wb_we_i && wb_sel_i[0];
                end
            end
            MCS_BUS_ACK: begin
                next_st.bus = MCS_BUS_IDLE;
            end
            default: begin
                next_st.bus = MCS_BUS_IDLE;
            end
        endcase

        // Register writes, taken with the request.
        if (wr) begin
            if (hit(wb_adr_i, `MCS_IDX_AIS)) begin
                next_st.sel      = mcs_input_t'(
                    wbyte[`MCS_AIS_SEL_HI:`MCS_AIS_SEL_LO]); // see R1
                next_st.src_sel  = wbyte[`MCS_AIS_SRC_SEL];  // see R2
                next_st.src_high = wbyte[`MCS_AIS_SRC_HIGH]; // see R3
                next_st.src_low  = wbyte[`MCS_AIS_SRC_LOW];  // see R4
            end
            if (hit(wb_adr_i, `MCS_IDX_BIAS)) begin
                next_st.code = wbyte[`MCS_BIAS_HI:`MCS_BIAS_LO]; // see R6
            end
            if (hit(wb_adr_i, `MCS_IDX_IRQ_STAT)) begin
                next_st.clr = wbyte[`MCS_SAT_HI:`MCS_SAT_LO];
            end
            if (hit(wb_adr_i, `MCS_IDX_IRQ_MASK)) begin
                next_st.mask = wbyte[`MCS_SAT_HI:`MCS_SAT_LO];
            end
            // The saturation register has no write path. // see R9
        end

        // Read mux; unmapped addresses read zero.
        if (hit(wb_adr_i, `MCS_IDX_AIS)) begin
            rbyte = ais_byte;
        end else if (hit(wb_adr_i, `MCS_IDX_BIAS)) begin
            rbyte = bias_byte;
        end else if (hit(wb_adr_i, `MCS_IDX_SAT)) begin
            rbyte = sat_byte;
        end else if (hit(wb_adr_i, `MCS_IDX_IRQ_STAT)) begin
            rbyte = stat_byte;
        end else if (hit(wb_adr_i, `MCS_IDX_IRQ_MASK)) begin
            rbyte = mask_byte;
        end
        if (st.bus == MCS_BUS_IDLE && req && !wb_we_i) begin
            next_st.dat = rbyte;
        end

        // Live saturation levels, sampled each cycle.
        next_st.sat = sat_live; // see R7 see R8

        // Routing decodes follow the stored fields.
        next_st.route     = onehot(next_st.sel); // see R1
        next_st.src_route = next_st.src_sel
                          ? onehot(next_st.sel) : 4'h0; // see R2

        // Level interrupt from unmasked sticky events.
        next_st.irq = |(evt_status & ~next_st.clr & next_st.mask);
    end

    // ============================================================
    // State register

    // Synchronous reset to the documented defaults.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st           <= '0;
            st.sel       <= mcs_input_t'(2'(
                `MCS_RST_AIS >> `MCS_AIS_SEL_LO)); // see R1
            st.src_sel   <= 1'b0;                 // see R2
            st.code      <= `MCS_RST_BIAS;        // see R6
            st.mask      <= `MCS_RST_MASK;
            st.route     <= 4'h1;
        end else begin
            st <= next_st;
        end
    end

    // ============================================================
    // Outputs, straight from the state register

    // Bus answer.
    assign wb_ack_o = (st.bus == MCS_BUS_ACK);
    assign wb_dat_o = {24'h000000, st.dat};

    // Path routing.
    assign input_sel_o              = st.sel;
    assign route_voltage_o          = st.route[0];
    assign route_ext_temp_input_a_o = st.route[1];
    assign route_ext_temp_input_b_o = st.route[2];
    assign route_int_temp_o         = st.route[3];

    // Source switches.
    assign src_to_input_o            = st.src_sel;
    assign src_on_voltage_o          = st.src_route[0];
    assign src_on_ext_temp_input_a_o = st.src_route[1];
    assign src_on_ext_temp_input_b_o = st.src_route[2];
    assign src_on_int_temp_o         = st.src_route[3];
    assign src_to_shunt_sense_high_o = st.src_high;
    assign src_to_shunt_sense_low_o  = st.src_low;

    // Source level and interrupt.
    assign bias_code_o = st.code;
    assign irq_o       = st.irq;

endmodule // mcs_top

// ==== logic/mcs_map.svh ====
// Purpose: Register map, field positions and reset values of the channel select block.
// Assumes: Registers sit on a 32-bit classic Wishbone bus, one aligned word each.
// Notes:   Byte address of a register is four times its index.
`ifndef MCS_MAP_SVH
`define MCS_MAP_SVH

// ============================================================
// Bus geometry
`define MCS_ADR_W        10
`define MCS_IDX_HI       9
`define MCS_IDX_LO       2
`define MCS_IDX_W        8

// ============================================================
// Register indices
`define MCS_IDX_AIS      8'h17
`define MCS_IDX_BIAS     8'h18
`define MCS_IDX_SAT      8'h44
`define MCS_IDX_IRQ_STAT 8'h50
`define MCS_IDX_IRQ_MASK 8'h51

// ============================================================
// Reset values
`define MCS_RST_AIS      8'h00
`define MCS_RST_BIAS     5'h00
`define MCS_RST_MASK     2'h0
`define MCS_RST_BYTE     8'h00

// ============================================================
// Field positions of the analog input select register
`define MCS_AIS_SEL_HI   7
`define MCS_AIS_SEL_LO   6
`define MCS_AIS_SRC_SEL  4
`define MCS_AIS_SRC_HIGH 3
`define MCS_AIS_SRC_LOW  2

// ============================================================
// Field positions of the bias current setting register
`define MCS_BIAS_HI      7
`define MCS_BIAS_LO      3

// ============================================================
// Saturation flags, interrupt status and mask share this layout
`define MCS_SAT_CUR      7
`define MCS_SAT_VOLT     6
`define MCS_SAT_HI       7
`define MCS_SAT_LO       6

`endif

// ==== logic/mcs_pkg.sv ====
// Purpose: Types shared by the channel select block.
// Assumes: Field widths come from mcs_map.svh.
// Notes:   All module state is held in the packed structs below.
`include "mcs_map.svh"

package mcs_pkg;

    // ============================================================
    // Measurement path input choice
    typedef enum logic [1:0] {
        MCS_IN_VOLT     = 2'b00,
        MCS_IN_EXT_A    = 2'b01,
        MCS_IN_EXT_B    = 2'b10,
        MCS_IN_INT_TEMP = 2'b11
    } mcs_input_t;

    // Bus slave cycle state.
    typedef enum logic [0:0] {
        MCS_BUS_IDLE = 1'b0,
        MCS_BUS_ACK  = 1'b1
    } mcs_bus_t;

    // ============================================================
    // State of the top module
    typedef struct packed {
        mcs_bus_t   bus;
        logic [7:0] dat;
        mcs_input_t sel;
        logic       src_sel;
        logic       src_high;
        logic       src_low;
        logic [4:0] code;
        logic [1:0] mask;
        logic [1:0] clr;
        logic       irq;
        logic [3:0] route;
        logic [3:0] src_route;
        logic [1:0] sat;
    } mcs_state_t;

    // State of the saturation event catcher.
    typedef struct packed {
        logic [1:0] prev;
        logic [1:0] status;
    } mcs_evt_state_t;

endpackage

// ==== logic/mcs_sat_events.sv ====
// Purpose: Turns saturation onsets into sticky event bits.
// Assumes: Saturation levels come from logic on clk_i.
// Notes:   A new onset in the clearing cycle keeps its bit set.
`include "mcs_map.svh"

module mcs_sat_events
    import mcs_pkg::*;
(
    // Clock and reset.
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Live saturation levels, current in bit 1.
    input  wire logic [1:0] sat_i,
    // Write-one-to-clear strobes, one cycle.
    input  wire logic [1:0] clr_i,
    // Sticky event bits.
    output logic [1:0]      status_o
);

    mcs_evt_state_t st;
    mcs_evt_state_t next_st;

    // ============================================================
    // Next state: a rising level sets, a clear strobe clears, set wins.
    always_comb begin
        next_st        = st;
        next_st.prev   = sat_i;
        next_st.status = (st.status & ~clr_i) | (sat_i & ~st.prev);
    end

    // Register the state.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign status_o = st.status;

endmodule // mcs_sat_events

// ==== test/mcs_host_model.sv ====
// Purpose: Host controller that issues classic Wishbone cycles.
// Assumes: The slave answers every request with an ack.
// Notes:   Waits are open; the bench timeout ends a hang.
`include "mcs_map.svh"
// ============================================================
module mcs_host_model (
    // Clock and slave answer.
    input  wire logic        clk_i,
    input  wire logic        ack_i,
    input  wire logic [31:0] rdat_i,
    // Request.
    output logic             cyc_o = 1'b0,
    output logic             stb_o = 1'b0,
    output logic             we_o  = 1'b0,
    output logic [9:0]       adr_o = 10'h000,
    output logic [3:0]       sel_o = 4'h0,
    output logic [31:0]      dat_o = 32'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    // One cycle: hold it until ack, then release and scramble the lines.
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d,
                        output logic [7:0] q);
        logic [7:0] v;
        v = (idx == `MCS_IDX_AIS) ? (d & 8'hDF) : d;
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o  <= w;
        adr_o <= {idx, 2'b00};
        sel_o <= 4'hF;
        dat_o <= {24'h0, v};
        do @(posedge clk_i); while (ack_i !== 1'b1);
        q = rdat_i[7:0];
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        adr_o <= ~adr_o;
        dat_o <= ~dat_o;
    endtask
endmodule // mcs_host_model

// ==== test/mcs_top_asserts.sv ====
// Purpose: Port-level checks of the channel select block.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Attached to every mcs_top by the bind below.
`include "mcs_map.svh"
// ============================================================
module mcs_checker (
    // Clock, reset and bus.
    input wire logic                  clk_i,
    input wire logic                  rst_i,
    input wire logic                  wb_cyc_i,
    input wire logic                  wb_stb_i,
    input wire logic                  wb_we_i,
    input wire logic [`MCS_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0]            wb_sel_i,
    input wire logic [31:0]           wb_dat_i,
    input wire logic [31:0]           wb_dat_o,
    input wire logic                  wb_ack_o,
    // Watched controls and flags.
    input wire logic                  cur_sat_i,
    input wire logic                  volt_sat_i,
    input wire logic [1:0]            input_sel_o,
    input wire logic                  route_voltage_o,
    input wire logic                  route_int_temp_o,
    input wire logic                  src_to_input_o,
    input wire logic                  src_on_int_temp_o,
    input wire logic                  src_to_shunt_sense_high_o,
    input wire logic                  src_to_shunt_sense_low_o,
    input wire logic [4:0]            bias_code_o,
    input wire logic                  irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Request taken, and a taken write to the low byte.
    wire logic       take  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic       wr_ok = take && wb_we_i && wb_sel_i[0];
    wire logic [7:0] idx   = wb_adr_i[9:2];
    // Bus answer timing.
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_answer_a: assert property (take |=> wb_ack_o)
        else $error("request not answered next cycle");
    // Stored fields follow the write data.
    sel_store_a: assert property (wr_ok && idx == `MCS_IDX_AIS |=>
        input_sel_o == $past(wb_dat_i[7:6])) else $error("selector not stored");
    switch_store_a: assert property (wr_ok && idx == `MCS_IDX_AIS |=>
        {src_to_input_o, src_to_shunt_sense_high_o, src_to_shunt_sense_low_o}
        == $past(wb_dat_i[4:2])) else $error("source switches not stored");
    bias_store_a: assert property (wr_ok && idx == `MCS_IDX_BIAS |=>
        bias_code_o == $past(wb_dat_i[7:3])) else $error("bias code not stored");
    // Routing decodes and source gating.
    route_map_a: assert property (route_voltage_o == (input_sel_o == 2'h0) &&
        route_int_temp_o == (input_sel_o == 2'h3)) else $error("route decode wrong");
    src_gate_a: assert property (src_on_int_temp_o ==
        (src_to_input_o && input_sel_o == 2'h3)) else $error("source gating wrong");
    // Flags read back the saturation levels of two cycles before.
    sat_read_a: assert property (take && !wb_we_i && idx == `MCS_IDX_SAT |=>
        wb_dat_o == {24'h0, $past(cur_sat_i, 2), $past(volt_sat_i, 2), 6'h0})
        else $error("saturation flags wrong");
    cover property (wr_ok && idx == `MCS_IDX_AIS);
    cover property (take && idx == `MCS_IDX_SAT);
    cover property (irq_o);
endmodule // mcs_checker

bind mcs_top mcs_checker u_chk (.*);

// ==== test/testbench.sv ====
// Purpose: Self-checking bench of the channel select block.
// Assumes: 125 MHz clock, reset held 20 cycles.
// Notes:   Register traffic goes through the host model.
`include "mcs_map.svh"
// ============================================================
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, rst_i = 1'b1, cur_sat_i = 1'b0, volt_sat_i = 1'b0;
    logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
    logic [9:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [1:0]  input_sel_o;
    logic [4:0]  bias_code_o;
    logic route_voltage_o, route_ext_temp_input_a_o, route_ext_temp_input_b_o;
    logic route_int_temp_o, src_to_input_o, src_on_voltage_o, src_on_int_temp_o;
    logic src_on_ext_temp_input_a_o, src_on_ext_temp_input_b_o;
    logic src_to_shunt_sense_high_o, src_to_shunt_sense_low_o;
    logic [7:0]  q;
    int fails = 0, n_compared = 0, cycles = 0;
    // Clock and cycle ceiling.
    always #4 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            complete_run();
        end
    end
    mcs_host_model host (.clk_i(clk_i), .ack_i(wb_ack_o), .rdat_i(wb_dat_o),
        .cyc_o(wb_cyc_i), .stb_o(wb_stb_i), .we_o(wb_we_i), .adr_o(wb_adr_i),
        .sel_o(wb_sel_i), .dat_o(wb_dat_i));
    mcs_top uut (.*);
    // Shared helpers.
    task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        host.xfer(1'b1, idx, d, q);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input string nm);
        host.xfer(1'b0, idx, 8'h00, q);
        check(nm, q, exp);
    endtask
    function automatic logic [7:0] routes();
        return {4'h0, route_int_temp_o, route_ext_temp_input_b_o,
                route_ext_temp_input_a_o, route_voltage_o};
    endfunction
    function automatic logic [7:0] srcs();
        return {4'h0, src_on_int_temp_o, src_on_ext_temp_input_b_o,
                src_on_ext_temp_input_a_o, src_on_voltage_o};
    endfunction
    // Reset values and an unmapped read.
    task automatic t_reset();
        check("route", routes(), 8'h01);
        check("switches", {src_to_input_o, src_to_shunt_sense_high_o,
            src_to_shunt_sense_low_o, bias_code_o}, 8'h00);
        rd(`MCS_IDX_AIS, 8'h00, "select");
        rd(`MCS_IDX_BIAS, 8'h00, "bias");
        rd(`MCS_IDX_SAT, 8'h00, "flags");
        rd(8'h33, 8'h00, "unmapped");
    endtask
    // Every input code with all source switches on, then off.
    task automatic t_select();
        for (int c = 0; c < 4; c++) begin
            wr(`MCS_IDX_AIS, {c[1:0], 6'h3C});
            check("route", routes(), 8'h01 << c);
            check("src_on", srcs(), 8'h01 << c);
            check("shunt", {6'h0, src_to_shunt_sense_high_o, src_to_shunt_sense_low_o},
                8'h03);
            rd(`MCS_IDX_AIS, {c[1:0], 6'h1C}, "select");
        end
        wr(`MCS_IDX_AIS, 8'h40);
        check("src_off", {srcs(), src_to_input_o, src_to_shunt_sense_high_o,
            src_to_shunt_sense_low_o} & 8'h7F, 8'h00);
    endtask
    // Level codes one above the bottom, in the middle and at the top.
    task automatic t_bias();
        logic [4:0] codes [3] = '{5'h01, 5'h10, 5'h1F};
        foreach (codes[i]) begin
            wr(`MCS_IDX_BIAS, {codes[i], 3'h7});
            check("bias_code", {3'h0, bias_code_o}, {3'h0, codes[i]});
            rd(`MCS_IDX_BIAS, {codes[i], 3'h0}, "bias");
        end
    endtask
    // Flags, a dropped write to them, and the event interrupt.
    task automatic t_sat();
        cur_sat_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rd(`MCS_IDX_SAT, 8'h80, "flags");
        check("irq_masked", {7'h0, irq_o}, 8'h00);
        wr(`MCS_IDX_SAT, 8'h40);
        rd(`MCS_IDX_SAT, 8'h80, "flags");
        volt_sat_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rd(`MCS_IDX_SAT, 8'hC0, "flags");
        rd(`MCS_IDX_IRQ_STAT, 8'hC0, "events");
        wr(`MCS_IDX_IRQ_MASK, 8'h40);
        repeat (2) @(posedge clk_i);
        check("irq", {7'h0, irq_o}, 8'h01);
        wr(`MCS_IDX_IRQ_STAT, 8'h40);
        repeat (2) @(posedge clk_i);
        check("irq", {7'h0, irq_o}, 8'h00);
        rd(`MCS_IDX_IRQ_STAT, 8'h80, "events");
        cur_sat_i <= 1'b0;
        volt_sat_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        rd(`MCS_IDX_SAT, 8'h00, "flags");
    endtask
    // Verdict and end of run.
    task automatic complete_run();
        $display("compared %0d failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Main sequence.
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_select();
        t_bias();
        t_sat();
        complete_run();
    end
endmodule // testbench
